//--- adc_power_mode_and_channel_sequencer_tb.sv
// self-checking bench of the power-mode and channel-sequencer control
`include "adcps_consts.svh"
`default_nettype none
module adc_power_mode_and_channel_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import adcps_pkg::*;

    logic           clk_i;
    logic           nrst_i;
    logic           sclk;
    logic           cs_n;
    logic           din;
    logic           conv_start_o;
    logic [3:0]     conv_channel_o;
    logic           range_o;
    logic           coding_o;
    logic           weak_o;
    adcps_pwr_out_t power_o;
    adcps_seq_t     seq_mode_o;
    logic [3:0]     last_ch;
    int             failures;
    int             n_compared;

    adcps_host host_u (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

    adcps_top dut_u
    (
        .clk_i              (clk_i),
        .nrst_i             (nrst_i),
        .ce_i               (1'b1),
        .sclk_i             (sclk),
        .cs_n_i             (cs_n),
        .din_i              (din),
        .conv_start_o       (conv_start_o),
        .conv_channel_o     (conv_channel_o),
        .range_single_ref_o (range_o),
        .coding_binary_o    (coding_o),
        .dout_weak_o        (weak_o),
        .power_o            (power_o),
        .seq_mode_o         (seq_mode_o)
    );

    // 250 MHz system clock
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // control word with write enable set; rcw is {range, coding, weak}
    function automatic logic [15:0] cw(input logic [1:0] sq, input logic [3:0] ad,
                                       input logic [1:0] pm, input logic [2:0] rcw);
        return {1'b1, sq[1], ad, pm, sq[0], rcw[0], rcw[2], rcw[1], 4'h0};
    endfunction

    // channel is read as the frame closes; settle time covers the 4-edge update
    task automatic frame(input logic [15:0] w);
        @(posedge clk_i);
        #1;
        host_u.xfer(w);
        last_ch = conv_channel_o;
        repeat (8) @(posedge clk_i);
        #1;
    endtask

    task automatic t_reset();
        check(16'(power_o), 16'h0007);
        check(16'(seq_mode_o), 16'h0000);
        check(16'({range_o, coding_o, weak_o, conv_channel_o}), 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_single();
        frame(cw(`ADCPS_SQ_SINGLE, 4'h5, `ADCPS_PM_NORMAL, 3'h7));
        check(16'({range_o, coding_o, weak_o}), 16'h0007);
        // write enable low: bits below must be ignored
        frame(16'h7FF0);
        check(16'(last_ch), 16'h0005);
        check(16'({range_o, coding_o, weak_o}), 16'h0007);
        check(16'(seq_mode_o), 16'h0000);
        $display("test single done");
    endtask

    task automatic t_mask();
        logic [15:0] w [5];
        logic [3:0]  exp [5];
        w   = '{16'h0000, 16'h0000, cw(`ADCPS_SQ_KEEP, 4'hF, `ADCPS_PM_NORMAL, 3'h4), 16'h0000, 16'h0000};
        exp = '{4'h1, 4'h4, 4'hA, 4'hF, 4'h1};
        frame(cw(`ADCPS_SQ_MASK_LOAD, 4'h0, `ADCPS_PM_NORMAL, 3'h0));
        check(16'(seq_mode_o), 16'h0001);
        // channels 15, 10, 4 and 1; not symmetric, so bit order shows
        frame(16'h8412);
        check(16'(seq_mode_o), 16'h0002);
        for (int i = 0; i < 5; i++)
        begin
            frame(w[i]);
            check(16'(last_ch), 16'(exp[i]));
        end
        check(16'({range_o, seq_mode_o}), 16'h0006);
        frame(cw(`ADCPS_SQ_SINGLE, 4'h3, `ADCPS_PM_NORMAL, 3'h0));
        check(16'(seq_mode_o), 16'h0000);
        frame(16'h0000);
        check(16'(last_ch), 16'h0003);
        $display("test mask done");
    endtask

    task automatic t_consec();
        logic [3:0] exp [4];
        exp = '{4'h0, 4'h1, 4'h2, 4'h0};
        frame(cw(`ADCPS_SQ_CONSEC, 4'h2, `ADCPS_PM_NORMAL, 3'h0));
        check(16'(seq_mode_o), 16'h0003);
        for (int i = 0; i < 4; i++)
        begin
            frame(16'h0000);
            check(16'(last_ch), 16'(exp[i]));
        end
        frame(cw(`ADCPS_SQ_SINGLE, 4'h0, `ADCPS_PM_NORMAL, 3'h0));
        check(16'(seq_mode_o), 16'h0000);
        $display("test consecutive done");
    endtask

    task automatic t_power();
        frame(cw(`ADCPS_SQ_SINGLE, 4'h0, `ADCPS_PM_FULL_OFF, 3'h0));
        check(16'(power_o), 16'h0000);
        frame(16'h0000);
        check(16'(power_o), 16'h0000);
        frame(cw(`ADCPS_SQ_SINGLE, 4'h0, `ADCPS_PM_AUTO_OFF, 3'h0));
        check(16'({power_o.core_on, power_o.ready}), 16'h0000);
        fork
            frame(16'h0000);
            begin
                repeat (40) @(posedge clk_i);
                #1;
                check(16'(power_o.ready), 16'h0000);
            end
        join
        // host waits past the 1 us wake before trusting a result
        repeat (150) @(posedge clk_i);
        #1;
        check(16'(power_o), 16'h0007);
        frame(cw(`ADCPS_SQ_SINGLE, 4'h0, `ADCPS_PM_AUTO_STBY, 3'h0));
        check(16'(power_o), 16'h0002);
        frame(16'h0000);
        check(16'(power_o), 16'h0007);
        frame(16'h0000);
        check(16'(power_o), 16'h0002);
        frame(cw(`ADCPS_SQ_SINGLE, 4'h0, `ADCPS_PM_NORMAL, 3'h0));
        check(16'(power_o), 16'h0007);
        $display("test power done");
    endtask

    // cut a hang short
    initial
    begin
        #100000;
        failures++;
        test_done();
    end

    initial
    begin
        failures   = 0;
        n_compared = 0;
        last_ch    = 4'h0;
        nrst_i     = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        t_reset();
        t_single();
        t_mask();
        t_consec();
        t_power();
        test_done();
    end
endmodule
`default_nettype wire

//--- adcps_consts.svh
// bit positions, reset values and timing counts of the power and sequencer control
`ifndef ADCPS_CONSTS_SVH
`define ADCPS_CONSTS_SVH

// serial word framing: control word sits in the upper 12 of 16 bits
`define ADCPS_WORD_BITS        5'h10
`define ADCPS_CTRL_LSB         4
// control bit positions inside the 12-bit control word
`define ADCPS_WRITE_EN_BIT     11
`define ADCPS_AUTO_CYCLE_BIT   10
`define ADCPS_CHAN_ADDR_MSB    9
`define ADCPS_CHAN_ADDR_LSB    6
`define ADCPS_POWER_SEL_HIGH   5
`define ADCPS_POWER_SEL_LOW    4
`define ADCPS_MASK_SELECT_BIT  3
`define ADCPS_DOUT_WEAK_BIT    2
`define ADCPS_RANGE_BIT        1
`define ADCPS_CODING_BIT       0
// power mode encodings {power_sel_high, power_sel_low}
`define ADCPS_PM_NORMAL        2'h3
`define ADCPS_PM_FULL_OFF      2'h2
`define ADCPS_PM_AUTO_OFF      2'h1
`define ADCPS_PM_AUTO_STBY     2'h0
// sequencer encodings {auto_cycle_bit, mask_select}
`define ADCPS_SQ_SINGLE        2'h0
`define ADCPS_SQ_MASK_LOAD     2'h1
`define ADCPS_SQ_KEEP          2'h2
`define ADCPS_SQ_CONSEC        2'h3
// reset values of the control settings
`define ADCPS_RST_PM           2'h3
`define ADCPS_RST_CHAN         4'h0
`define ADCPS_RST_MASK         16'h0000
// wake-up from auto shutdown
`define ADCPS_CLK_MHZ          250
`define ADCPS_WAKE_NS          1000
`define ADCPS_WAKE_CYC         ((`ADCPS_WAKE_NS * `ADCPS_CLK_MHZ + 999) / 1000)
`define ADCPS_WAKE_W           9

`endif

//--- adcps_host.sv
// host serial port model: drives frames of 16 bits msb first, link clock idle between frames
`default_nettype none
module adcps_host
(
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // link clock rests high outside frames, so no stray falling edge
    initial
    begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end

    // one frame at a 30 ns link period; data set while sclk high, taken on its fall
    task automatic xfer(input logic [15:0] word);
        cs_n_o = 1'b0;
        #15;
        for (int i = 15; i >= 0; i--)
        begin
            din_o  = word[i];
            #15 sclk_o = 1'b0;
            #15 sclk_o = 1'b1;
        end
        #15 cs_n_o = 1'b1;
        // released data line shows the inverse, never a held value
        din_o = ~din_o;
        // cs high gap well above the 16 ns minimum
        #60;
    endtask
endmodule
`default_nettype wire

//--- adcps_link.sv
// serial-clock domain: shifts in the input word and steps the conversion clock count
`include "adcps_consts.svh"
`default_nettype none
module adcps_link
(
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        din_i,
    output logic      [15:0] word_o,
    output logic             done_o
);
    logic        armed_ff;
    logic        nxt_armed;
    logic [4:0]  cnt_ff;
    logic [4:0]  nxt_cnt;
    logic [15:0] shift_ff;
    logic [15:0] nxt_shift;

    // first falling edge of a frame restarts the count; edges past 16 are ignored
    always_comb
    begin
        nxt_armed = 1'b0;
        nxt_cnt   = cnt_ff;
        nxt_shift = shift_ff;
        if (armed_ff)
        begin
            nxt_cnt   = 5'h01;
            nxt_shift = {shift_ff[14:0], din_i};     // msb first
        end
        else if (cnt_ff != `ADCPS_WORD_BITS)
        begin
            nxt_cnt   = cnt_ff + 5'h01;              // same edge steps the sar
            nxt_shift = {shift_ff[14:0], din_i};
        end
    end

    // chip select high arms the next frame; sclk may stand still meanwhile
    always_ff @(negedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
            armed_ff <= 1'b1;
        else
            armed_ff <= nxt_armed;
    end

    // word and count hold still between frames, so the other side can read them
    always_ff @(negedge sclk_i)
    begin
        cnt_ff   <= nxt_cnt;
        shift_ff <= nxt_shift;
    end

    assign word_o = shift_ff;
    assign done_o = (cnt_ff == `ADCPS_WORD_BITS);    // held past cs rise until the next frame's first edge
endmodule
`default_nettype wire

//--- adcps_pkg.sv
// types shared by the power-mode and channel-sequencer control
`default_nettype none
package adcps_pkg;

    // sequencer state
    typedef enum logic [1:0] {
        SEQ_SINGLE    = 2'b00,
        SEQ_MASK_LOAD = 2'b01,
        SEQ_MASK_RUN  = 2'b10,
        SEQ_CONSEC    = 2'b11
    } adcps_seq_t;

    // power state of the converter core
    typedef enum logic [2:0] {
        PWR_ON       = 3'b000,
        PWR_FULL_OFF = 3'b001,
        PWR_AUTO_OFF = 3'b010,
        PWR_WAKE     = 3'b011,
        PWR_STBY     = 3'b100,
        PWR_DUMMY    = 3'b101
    } adcps_pwr_t;

    // retained control settings
    typedef struct packed {
        logic       power_sel_high;
        logic       power_sel_low;
        logic [3:0] channel_address;
        logic       range_single_ref;
        logic       coding_binary;
        logic       dout_weak;
    } adcps_ctrl_t;

    // power status toward the analog core
    typedef struct packed {
        logic core_on;
        logic bias_on;
        logic ready;
    } adcps_pwr_out_t;

endpackage
`default_nettype wire

//--- adcps_sync.sv
// two-flop synchroniser for two level signals from the serial-clock side
`default_nettype none
module adcps_sync
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic [1:0] async_i,
    output logic      [1:0] sync_o
);
    logic [1:0] meta_ff;
    logic [1:0] nxt_meta;
    logic [1:0] sync_ff;
    logic [1:0] nxt_sync;

    // first stage feeds only the second stage; reset level is select high, done low, though done idles high after a frame
    always_comb
    begin
        nxt_meta = async_i;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            meta_ff <= 2'h2;
            sync_ff <= 2'h2;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_o = sync_ff;
endmodule
`default_nettype wire

//--- adcps_top.sv
// power-mode and channel-sequencer control of a 16-channel serial converter
//
// Operation
// - power bits 1,1: stay fully powered regardless of inputs.
// - power bits 1,0: full shutdown, settings kept, exit only via new write.
// - power bits 0,1: shut down after each updating conversion; wake takes 1 us. An update ending inside the wake is ignored and the core stays on.
// - power bits 0,0: partial standby, bias on, ready after one dummy transfer.
// - sequencer bits 0,0: convert channel named by previous write's address.
// - sequencer bits 0,1: next transfer's input word is the channel mask.
// - after mask load convert masked channels in turn, one per frame.
// - sequencer bits 1,0: update other settings, running sequence untouched.
// - sequencer bits 1,1: convert channel 0 up to addressed final channel.
// - mask is 16-bit write-only, shifted in on 16 falling edges.
// - mask captured only if previous control write chose 0,1.
// - mask msb first, one bit per channel, set bit includes channel.
// - ascending order from lowest, until write with sequencer bits not 1,0.
// - serial clock both shifts data and clocks the conversion.
// - control bit 1 chooses single or double reference input range.
// - top control bit is write enable; zero leaves settings unchanged.
// - address bits 9..6 take effect at end of present conversion.
// - mask-select bit at position 3 pairs with sequence bit.
`include "adcps_consts.svh"
`default_nettype none
module adcps_top
(
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   ce_i,
    input  wire logic                   sclk_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   din_i,
    output logic                        conv_start_o,
    output logic      [3:0]             conv_channel_o,
    output logic                        range_single_ref_o,
    output logic                        coding_binary_o,
    output logic                        dout_weak_o,
    output adcps_pkg::adcps_pwr_out_t   power_o,
    output adcps_pkg::adcps_seq_t       seq_mode_o
);
    import adcps_pkg::*;

    localparam logic [`ADCPS_WAKE_W-1:0] WAKE_CYC = `ADCPS_WAKE_W'(`ADCPS_WAKE_CYC);
    // next set bit above cur, wrapping; cur itself when mask holds nothing else
    function automatic logic [3:0] next_masked(input logic [15:0] mask, input logic [3:0] cur);
        logic [3:0] idx;
        logic [3:0] res;
        logic       hit;
        res = cur;
        hit = 1'b0;
        for (int i = 1; i <= 16; i++)
        begin
            idx = cur + 4'(i);
            if (!hit && mask[idx])
            begin
                res = idx;
                hit = 1'b1;
            end
        end
        return res;
    endfunction

    logic [15:0] link_word;
    logic        link_done;
    logic [1:0]  sync_out;
    logic        cs_n_s;
    logic        done_s;

    // serial-clock side logic
    adcps_link u_link
    (
        .sclk_i (sclk_i),
        .cs_n_i (cs_n_i),
        .din_i  (din_i),
        .word_o (link_word),
        .done_o (link_done)
    );

    // bring chip select and word-complete into the system clock
    adcps_sync u_sync
    (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i ({cs_n_i, link_done}),
        .sync_o  (sync_out)
    );

    assign cs_n_s = sync_out[1];
    assign done_s = sync_out[0];

    // frame edge detection
    logic cs_d_ff;
    logic nxt_cs_d;
    logic seen_ff;
    logic nxt_seen;
    logic cs_fall;
    logic frame_end;

    assign cs_fall   = cs_d_ff && !cs_n_s;
    // word is stable while chip select stays high, so it is read only then
    assign frame_end = !cs_d_ff && cs_n_s && seen_ff && done_s;
    always_comb
    begin
        nxt_cs_d = cs_n_s;
        // count must drop below 16 inside the frame, so an edgeless frame never reuses the old word
        nxt_seen = (seen_ff | (!cs_n_s && !done_s)) && !frame_end;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            cs_d_ff <= 1'b1;
            seen_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            cs_d_ff <= nxt_cs_d;
            seen_ff <= nxt_seen;
        end
    end

    // decoded fields of the finished word
    logic [11:0] ctrl_word;
    logic        wr_en;
    logic [1:0]  seq_bits;
    logic [1:0]  pm_bits;
    assign ctrl_word = link_word[15:`ADCPS_CTRL_LSB];
    assign wr_en     = ctrl_word[`ADCPS_WRITE_EN_BIT];
    assign seq_bits  = {ctrl_word[`ADCPS_AUTO_CYCLE_BIT], ctrl_word[`ADCPS_MASK_SELECT_BIT]};
    assign pm_bits   = {ctrl_word[`ADCPS_POWER_SEL_HIGH], ctrl_word[`ADCPS_POWER_SEL_LOW]};
    // control and sequencer state
    adcps_ctrl_t ctrl_ff;
    adcps_ctrl_t nxt_ctrl;
    adcps_seq_t  seq_ff;
    adcps_seq_t  nxt_seq;
    logic [15:0] mask_ff;
    logic [15:0] nxt_mask;
    logic [3:0]  chan_ff;
    logic [3:0]  nxt_chan;
    logic        upd_ff;
    logic        nxt_upd;

    // all decisions fall at the end of a conversion, for the next transfer
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_seq  = seq_ff;
        nxt_mask = mask_ff;
        nxt_chan = chan_ff;
        nxt_upd  = 1'b0;
        if (frame_end)
        begin
            if (seq_ff == SEQ_MASK_LOAD)
            begin
                // this word is the mask, never a control write
                nxt_mask = link_word;
                nxt_seq  = SEQ_MASK_RUN;
                nxt_chan = next_masked(link_word, 4'hF);               // lowest first
            end
            else if (wr_en)
            begin
                nxt_upd                  = 1'b1;
                nxt_ctrl.power_sel_high  = pm_bits[1];
                nxt_ctrl.power_sel_low   = pm_bits[0];
                nxt_ctrl.channel_address = ctrl_word[`ADCPS_CHAN_ADDR_MSB:`ADCPS_CHAN_ADDR_LSB];
                nxt_ctrl.range_single_ref = ctrl_word[`ADCPS_RANGE_BIT];
                nxt_ctrl.coding_binary   = ctrl_word[`ADCPS_CODING_BIT];
                nxt_ctrl.dout_weak       = ctrl_word[`ADCPS_DOUT_WEAK_BIT];
                case (seq_bits)
                    `ADCPS_SQ_SINGLE:
                    begin
                        nxt_seq  = SEQ_SINGLE;
                        nxt_chan = nxt_ctrl.channel_address;
                    end
                    `ADCPS_SQ_MASK_LOAD:
                    begin
                        nxt_seq  = SEQ_MASK_LOAD;
                        nxt_chan = nxt_ctrl.channel_address;
                    end
                    `ADCPS_SQ_CONSEC:
                    begin
                        nxt_seq  = SEQ_CONSEC;
                        nxt_chan = 4'h0;
                    end
                    default:
                    begin
                        // sequence runs on; only the other fields changed
                        case (seq_ff)
                            SEQ_MASK_RUN: nxt_chan = next_masked(mask_ff, chan_ff);
                            SEQ_CONSEC:   nxt_chan = (chan_ff == nxt_ctrl.channel_address) ? 4'h0 : chan_ff + 4'h1;
                            default:      nxt_chan = nxt_ctrl.channel_address;
                        endcase
                    end
                endcase
            end
            else
            begin
                // no write: mask and position carry on untouched
                case (seq_ff)
                    SEQ_MASK_RUN: nxt_chan = next_masked(mask_ff, chan_ff);
                    SEQ_CONSEC:   nxt_chan = (chan_ff == ctrl_ff.channel_address) ? 4'h0 : chan_ff + 4'h1;
                    default:      nxt_chan = ctrl_ff.channel_address;
                endcase
            end
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            ctrl_ff <= '{power_sel_high: 1'(`ADCPS_RST_PM >> 1), power_sel_low: 1'(`ADCPS_RST_PM & 2'h1),
                         channel_address: `ADCPS_RST_CHAN, range_single_ref: 1'b0,
                         coding_binary: 1'b0, dout_weak: 1'b0};
            seq_ff  <= SEQ_SINGLE;
            mask_ff <= `ADCPS_RST_MASK;
            chan_ff <= `ADCPS_RST_CHAN;
            upd_ff  <= 1'b0;
        end
        else if (ce_i)
        begin
            ctrl_ff <= nxt_ctrl;
            seq_ff  <= nxt_seq;
            mask_ff <= nxt_mask;
            chan_ff <= nxt_chan;
            upd_ff  <= nxt_upd;
        end
    end

    // power state machine
    adcps_pwr_t               pwr_ff;
    adcps_pwr_t               nxt_pwr;
    logic [`ADCPS_WAKE_W-1:0] wake_ff;
    logic [`ADCPS_WAKE_W-1:0] nxt_wake;
    logic [1:0]               pm_cur;
    assign pm_cur = {ctrl_ff.power_sel_high, ctrl_ff.power_sel_low};
    // runs one cycle after the control update so it sees the new mode
    always_comb
    begin
        nxt_pwr  = pwr_ff;
        nxt_wake = wake_ff;
        case (pm_cur)
            `ADCPS_PM_NORMAL:
                nxt_pwr = PWR_ON;
            `ADCPS_PM_FULL_OFF:
                nxt_pwr = PWR_FULL_OFF;                                // held until pm rewritten
            `ADCPS_PM_AUTO_OFF:
            begin
                case (pwr_ff)
                    PWR_AUTO_OFF:
                        if (cs_fall)
                        begin
                            nxt_pwr  = PWR_WAKE;
                            nxt_wake = WAKE_CYC;
                        end
                    PWR_WAKE:
                        if (wake_ff == `ADCPS_WAKE_W'(1))
                            nxt_pwr = PWR_ON;
                        else
                            nxt_wake = wake_ff - `ADCPS_WAKE_W'(1);
                    default:
                        if (upd_ff)
                            nxt_pwr = PWR_AUTO_OFF;                    // only after an updating conversion
                        else if (pwr_ff != PWR_ON)
                            nxt_pwr = PWR_AUTO_OFF;
                endcase
            end
            default:
            begin
                // standby keeps the bias; first frame after wake is a dummy
                case (pwr_ff)
                    PWR_STBY:
                        if (cs_fall)
                            nxt_pwr = PWR_DUMMY;
                    PWR_DUMMY:
                        if (frame_end)
                            nxt_pwr = PWR_ON;
                    PWR_ON:
                        if (upd_ff || frame_end)
                            nxt_pwr = PWR_STBY;
                    default:
                        nxt_pwr = PWR_STBY;
                endcase
            end
        endcase
    end
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            pwr_ff  <= PWR_ON;
            wake_ff <= '0;
        end
        else if (ce_i)
        begin
            pwr_ff  <= nxt_pwr;
            wake_ff <= nxt_wake;
        end
    end

    // conversion start marker and registered outputs
    logic        start_ff;
    logic        nxt_start;
    logic [3:0]  conv_ch_ff;
    logic [3:0]  nxt_conv_ch;
    // a start in a powered-down state is still flagged so the core can wake
    always_comb
    begin
        nxt_start   = cs_fall;
        nxt_conv_ch = cs_fall ? chan_ff : conv_ch_ff;
    end
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            start_ff   <= 1'b0;
            conv_ch_ff <= `ADCPS_RST_CHAN;
        end
        else if (ce_i)
        begin
            start_ff   <= nxt_start;
            conv_ch_ff <= nxt_conv_ch;
        end
    end

    assign conv_start_o       = start_ff;
    assign conv_channel_o     = conv_ch_ff;
    assign range_single_ref_o = ctrl_ff.range_single_ref;
    assign coding_binary_o    = ctrl_ff.coding_binary;
    assign dout_weak_o        = ctrl_ff.dout_weak;
    assign seq_mode_o         = seq_ff;
    assign power_o.core_on    = (pwr_ff == PWR_ON) || (pwr_ff == PWR_WAKE) || (pwr_ff == PWR_DUMMY);
    assign power_o.bias_on    = (pwr_ff != PWR_FULL_OFF) && (pwr_ff != PWR_AUTO_OFF);
    assign power_o.ready      = (pwr_ff == PWR_ON);
endmodule
`default_nettype wire

//--- adcps_top_checker.sv
// concurrent checks on the ports of the power and sequencer control
`default_nettype none
module adcps_top_checker
(
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      ce_i,
    input  wire logic                      sclk_i,
    input  wire logic                      cs_n_i,
    input  wire logic                      din_i,
    input  wire logic                      conv_start_o,
    input  wire logic [3:0]                conv_channel_o,
    input  wire logic                      range_single_ref_o,
    input  wire logic                      coding_binary_o,
    input  wire logic                      dout_weak_o,
    input  wire adcps_pkg::adcps_pwr_out_t power_o,
    input  wire adcps_pkg::adcps_seq_t     seq_mode_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import adcps_pkg::*;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
        else $error("conversion start wider than one cycle");
    AST_START_IN_FRAME: assert property (conv_start_o |-> !$past(cs_n_i))
        else $error("conversion start without chip select low");
    AST_START_FOLLOWS_CS: assert property ($fell(cs_n_i) |-> ##[1:4] conv_start_o)
        else $error("chip select fall gave no conversion start");
    AST_CHAN_AT_START: assert property ($changed(conv_channel_o) |-> conv_start_o || $past(conv_start_o))
        else $error("channel changed away from a conversion start");
    AST_READY_FULL_POWER: assert property (power_o.ready |-> power_o.core_on && power_o.bias_on)
        else $error("ready while part of the core is off");
    AST_CORE_NEEDS_BIAS: assert property (power_o.core_on |-> power_o.bias_on)
        else $error("core on with bias off");
    AST_SEQ_AT_FRAME_END: assert property ($changed(seq_mode_o) |-> $past(cs_n_i) && $past(cs_n_i, 2))
        else $error("sequencer mode changed inside a frame");
    AST_CTRL_AT_FRAME_END: assert property
        ($changed({range_single_ref_o, coding_binary_o, dout_weak_o}) |-> $past(cs_n_i) && $past(cs_n_i, 2))
        else $error("control bits changed inside a frame");

    // main scenarios reached
    COV_START: cover property (conv_start_o);
    COV_MASK_RUN: cover property (seq_mode_o == SEQ_MASK_RUN);
    COV_STANDBY: cover property (power_o == 3'h2);
endmodule

bind adcps_top adcps_top_checker chk_u
(
    .clk_i              (clk_i),
    .nrst_i             (nrst_i),
    .ce_i               (ce_i),
    .sclk_i             (sclk_i),
    .cs_n_i             (cs_n_i),
    .din_i              (din_i),
    .conv_start_o       (conv_start_o),
    .conv_channel_o     (conv_channel_o),
    .range_single_ref_o (range_single_ref_o),
    .coding_binary_o    (coding_binary_o),
    .dout_weak_o        (dout_weak_o),
    .power_o            (power_o),
    .seq_mode_o         (seq_mode_o)
);
`default_nettype wire
